/* hw/eas_pkg.sv */
// Constants for the external access steering block.
// Assumes a 16-bit core address space and one 100 MHz core clock.
package eas_pkg;
    // Address width of the core memory bus.
    localparam int ADDR_W = 16;
    // Number of port registers that can be redirected outward.
    localparam int PORT_REGS = 4;
    // Special-purpose partition bounds, inclusive.
    localparam logic [15:0] SP_LO = 16'h2000;
    localparam logic [15:0] SP_HI = 16'h207f;
    // Program partition bounds, inclusive.
    localparam logic [15:0] PROG_LO = 16'h2080;
    localparam logic [15:0] PROG_HI = 16'h7fff;
    // Addresses at or above this always go to the external bus.
    localparam logic [15:0] EXT_ONLY_LO = 16'h8000;
    // Internal port register addresses: latch 3, latch 4, pin 3, pin 4.
    localparam logic [15:0] PORT_REG_ADDR [PORT_REGS] = '{16'h1fd0, 16'h1fd1, 16'h1fd2, 16'h1fd3};
    // External locations that replace them when external access is active.
    localparam logic [15:0] EXT_PORT_ADDR [PORT_REGS] = '{16'h1ffc, 16'h1ffd, 16'h1ffe, 16'h1fff};
    // Length of one external bus cycle and of the idle gap after it, in clocks.
    localparam logic [2:0] EXT_CYCLE_LEN = 3'h3;
    localparam logic [2:0] IDLE_GAP_LEN = 3'h1;
    localparam logic [2:0] CNT_ONE = 3'h1;
    localparam logic [2:0] CNT_ZERO = 3'h0;

    // Sequencer states.
    typedef enum logic [1:0] {
        EAS_IDLE,
        EAS_BUS,
        EAS_GAP
    } eas_state_e;

    // Whole state of the steering block.
    typedef struct packed {
        eas_state_e st;
        logic ea_active;
        logic prog_mode;
        logic [2:0] cnt;
        logic int_sel;
        logic ext_start;
        logic ext_we;
        logic [15:0] ext_addr;
    } eas_state_s;
endpackage : eas_pkg

/* hw/eas_steer.sv */
// External access steering: routes core accesses to internal memory or the external bus.
// Assumes all inputs are synchronous to sys_clk_in and the core waits on acc_ready_out.
//
// Notes on behaviour
// - Partition accesses go internal when select is high, external when low.
// - Addresses outside the two partitions, other than the port registers, ignore the select level.
// - Programming voltage seen at reset release enters programming mode.
// - Select pin changes after reset do not change steering.
// - Without external access, idle gaps follow bus cycles; ports 3/4 usable between cycles.
// - With external access, ports 3 and 4 serve only the bus.
// - With external access, port register accesses go to 1FFC-1FFF externally.
`timescale 1ns/1ps
module eas_steer
    import eas_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // External access pin and its programming-voltage detector.
    input wire logic external_access_select_n_in,
    input wire logic vpp_detect_in,
    // Core access request.
    input wire logic acc_req_in,
    input wire logic [15:0] acc_addr_in,
    input wire logic acc_we_in,
    output logic acc_ready_out,
    // Steering results.
    output logic int_sel_out,
    output logic ext_start_out,
    output logic ext_we_out,
    output logic [15:0] ext_addr_out,
    output logic ext_busy_out,
    // Mode and port status.
    output logic ext_access_active_out,
    output logic prog_mode_out,
    output logic port_gpio_en_out
);

    ////////////////////////////////////////////////////////////////////////////
    eas_state_s q;
    eas_state_s d;
    logic taken;
    logic in_part;
    logic ext_only;
    logic [PORT_REGS-1:0] port_hit;
    logic [15:0] port_ext_addr;

    // Per-register compare of the incoming address against the port registers.
    genvar gi;
    generate
        for (gi = 0; gi < PORT_REGS; gi++) begin : g_port
            assign port_hit[gi] = (acc_addr_in == PORT_REG_ADDR[gi]);
        end
    endgenerate

    // Pick the external location matching the hit port register.
    always_comb begin
        port_ext_addr = acc_addr_in;
        for (int i = 0; i < PORT_REGS; i++) begin
            if (port_hit[i]) begin
                port_ext_addr = EXT_PORT_ADDR[i];
            end
        end
    end

    // Address classification; the select level plays no part here.
    assign in_part = ((acc_addr_in >= SP_LO) && (acc_addr_in <= SP_HI))
        || ((acc_addr_in >= PROG_LO) && (acc_addr_in <= PROG_HI));
    assign ext_only = (acc_addr_in >= EXT_ONLY_LO);

    // Requests are refused in programming mode and while the bus or gap runs.
    assign acc_ready_out = (q.st == EAS_IDLE) && !q.prog_mode;
    assign taken = acc_req_in && acc_ready_out;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic. Under reset the pin levels are sampled every cycle, so
    // the value standing at the last edge with reset high is the one that is kept.
    always_comb begin
        d = q;
        d.int_sel = 1'b0;
        d.ext_start = 1'b0;
        if (reset_in) begin
            d.st = EAS_IDLE;
            d.cnt = CNT_ZERO;
            d.ext_we = 1'b0;
            d.ext_addr = '0;
            d.ea_active = !external_access_select_n_in;
            d.prog_mode = vpp_detect_in;
        end else begin
            // The mode flags are never written outside reset, so pin changes are ignored.
            case (q.st)
                EAS_IDLE: begin
                    if (taken) begin
                        d.ext_we = acc_we_in;
                        if (q.ea_active && (port_hit != '0)) begin
                            d.ext_start = 1'b1;
                            d.ext_addr = port_ext_addr;
                        end else if (ext_only || (in_part && q.ea_active)) begin
                            d.ext_start = 1'b1;
                            d.ext_addr = acc_addr_in;
                        end else begin
                            d.int_sel = 1'b1;
                        end
                        if (d.ext_start) begin
                            d.st = EAS_BUS;
                            d.cnt = EXT_CYCLE_LEN;
                        end
                    end
                end
                EAS_BUS: begin
                    d.cnt = q.cnt - CNT_ONE;
                    if (q.cnt == CNT_ONE) begin
                        // Back-to-back cycles are allowed only when the pins are bus-only.
                        if (q.ea_active) begin
                            d.st = EAS_IDLE;
                        end else begin
                            d.st = EAS_GAP;
                            d.cnt = IDLE_GAP_LEN;
                        end
                    end
                end
                EAS_GAP: begin
                    d.cnt = q.cnt - CNT_ONE;
                    if (q.cnt == CNT_ONE) begin
                        d.st = EAS_IDLE;
                    end
                end
                default: begin
                    d.st = EAS_IDLE;
                    d.cnt = CNT_ZERO;
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge sys_clk_in) begin
        q <= d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register; the port enable is also gated by reset_in.
    assign int_sel_out = q.int_sel;
    assign ext_start_out = q.ext_start;
    assign ext_we_out = q.ext_we;
    assign ext_addr_out = q.ext_addr;
    assign ext_busy_out = (q.st == EAS_BUS);
    assign ext_access_active_out = q.ea_active;
    assign prog_mode_out = q.prog_mode;
    // Ports 3/4 are general I/O only between cycles and only without external access.
    assign port_gpio_en_out = !q.ea_active && (q.st != EAS_BUS) && !reset_in;

    ////////////////////////////////////////////////////////////////////////////
    // Checks. All of them are silenced while reset is high; the capture checks
    // look at the first edge after release, where the flags must already stand.
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    a_flag_hold_stable: assert property ($past(!reset_in) |-> $stable(q.ea_active))
        else $error("External access flag changed after reset.");
    a_ea_flag_capture: assert property ($fell(reset_in)
        |-> ext_access_active_out == !$past(external_access_select_n_in))
        else $error("External access flag not taken from the pin at release.");
    a_prog_mode_capture: assert property ($fell(reset_in)
        |-> prog_mode_out == $past(vpp_detect_in))
        else $error("Programming mode not taken from the detector at release.");
    a_part_goes_internal: assert property (taken && in_part && !ext_access_active_out
        |=> int_sel_out && !ext_start_out)
        else $error("Partition access did not go internal.");
    a_part_goes_external: assert property (taken && in_part && ext_access_active_out
        |=> ext_start_out && ext_addr_out == $past(acc_addr_in))
        else $error("Partition access did not go external.");
    a_other_ignores_sel: assert property (taken && !in_part && !ext_only && port_hit == '0
        |=> int_sel_out)
        else $error("Access outside partitions did not stay internal.");
    a_port_redirect_addr: assert property (taken && ext_access_active_out && port_hit[3]
        |=> ext_start_out && ext_addr_out == EXT_PORT_ADDR[3])
        else $error("Port register access not redirected outward.");
    a_gap_after_cycle: assert property ($fell(ext_busy_out) && !ext_access_active_out
        |-> !acc_ready_out && port_gpio_en_out ##1 acc_ready_out)
        else $error("Idle gap after a bus cycle missing.");
    a_ports_bus_only: assert property (ext_access_active_out |-> !port_gpio_en_out)
        else $error("Ports offered as I/O with external access active.");
    a_cycle_length: assert property ($rose(ext_busy_out)
        |-> ext_busy_out [*3] ##1 !ext_busy_out)
        else $error("External bus cycle has the wrong length.");

    // The programming flag is a second capture of the pin, so it must hold just as firmly.
    a_prog_flag_hold: assert property ($past(!reset_in) |-> $stable(prog_mode_out))
        else $error("Programming flag changed after reset.");
    // A part in programming mode must not start any access of its own.
    a_prog_no_route: assert property (prog_mode_out |-> !int_sel_out && !ext_start_out)
        else $error("Access routed while in programming mode.");
    // High addresses have no internal memory behind them, whatever the pin said.
    a_high_goes_out: assert property (taken && ext_only
        |=> ext_start_out && ext_addr_out == $past(acc_addr_in))
        else $error("High address access did not go external.");
    // Without external access the port registers are ordinary internal locations.
    a_port_stays_inside: assert property (taken && !ext_access_active_out
        && port_hit != '0 |=> int_sel_out && !ext_start_out)
        else $error("Port register access left the chip without external access.");
    // The lowest port register must land on the lowest of the four external locations.
    a_port_redirect_low: assert property (taken && ext_access_active_out && port_hit[0]
        |=> ext_start_out && ext_addr_out == EXT_PORT_ADDR[0])
        else $error("First port register not redirected outward.");
    // Reads and writes alike become bus cycles, so the direction must travel with them.
    a_write_flag_kept: assert property (taken |=> ext_we_out == $past(acc_we_in))
        else $error("Write flag not carried to the bus.");
    // No request may slip in while a bus cycle still owns the pins.
    a_busy_refuses_req: assert property (ext_busy_out |-> !acc_ready_out)
        else $error("Request accepted during a bus cycle.");
    // With the pins dedicated to the bus no gap is needed, so the next take may follow.
    a_active_no_gap: assert property ($fell(ext_busy_out) && ext_access_active_out
        |-> acc_ready_out)
        else $error("Idle gap inserted with external access active.");

    c_internal_access: cover property (taken ##1 int_sel_out);
    c_port_redirect: cover property (taken && ext_access_active_out && port_hit != '0);
    c_gap_cycle: cover property ($fell(ext_busy_out) && !ext_access_active_out);
    c_prog_entry: cover property ($fell(reset_in) ##0 prog_mode_out);
    c_active_back_to_back: cover property ($fell(ext_busy_out) && ext_access_active_out && taken);

endmodule : eas_steer

/* test/eas_ext_mem.sv */
// Behavioural external memory on the multiplexed bus, seen from its decode side.
// Assumes each bus cycle is announced by one ext_start pulse on the core clock.
`timescale 1ns/1ps
module eas_ext_mem (
    // Clock and bus cycle start.
    input wire logic clk_in,
    input wire logic start_in,
    input wire logic [15:0] addr_in,
    // Count of bus cycles and the last address decoded.
    output logic [7:0] hits_out = 8'h00,
    output logic [15:0] last_addr_out = 16'h0000
);
    // Decode every bus cycle; the count lets the bench prove no cycle is lost or doubled.
    always @(posedge clk_in) begin
        if (start_in === 1'b1) begin
            hits_out <= hits_out + 8'h01;
            last_addr_out <= addr_in;
        end
    end
endmodule : eas_ext_mem

/* test/test_external_access_steering.sv */
// Self-checking bench for the steering block with an external memory model.
// Assumes a request is taken at a rising edge where the block shows ready high.
`timescale 1ns/1ps
module test_external_access_steering;
    import eas_pkg::*;
    logic sys_clk_in = 1'b0, reset_in = 1'b1, sel_n = 1'b1, vpp = 1'b0, req = 1'b0, we = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic rdy, isel, estart, ewe, ebusy, eact, pmode, gpio;
    logic [15:0] eaddr, last_addr, last_ea = 16'h0000;
    logic [7:0] hits, ext_cnt = 8'h00;
    logic [16:0] exp_q [$];
    logic [31:0] rnd = 32'd55174;
    int num_errors = 0, samples_checked = 0, cycles = 0;
    // Free-running 100 MHz core clock.
    always #5 sys_clk_in = ~sys_clk_in;
    eas_steer i_dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
        .external_access_select_n_in(sel_n), .vpp_detect_in(vpp), .acc_req_in(req),
        .acc_addr_in(addr), .acc_we_in(we), .acc_ready_out(rdy), .int_sel_out(isel),
        .ext_start_out(estart), .ext_we_out(ewe), .ext_addr_out(eaddr), .ext_busy_out(ebusy),
        .ext_access_active_out(eact), .prog_mode_out(pmode), .port_gpio_en_out(gpio));
    eas_ext_mem i_mem (.clk_in(sys_clk_in), .start_in(estart), .addr_in(eaddr),
        .hits_out(hits), .last_addr_out(last_addr));
    ////////////////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and random source.
    task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wrap_up();
        $display("checked %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    // A hang is cut short well past the hundred or so cycles the tests need.
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            wrap_up();
        end
    end
    // Every routing pulse consumes the oldest note; internal notes carry no address.
    always @(negedge sys_clk_in) begin
        if (isel === 1'b1 || estart === 1'b1) begin
            if (exp_q.size() == 0) check("pulse without note", 17'h00001, 17'h00000);
            else if (exp_q[0][16]) check("route", {estart, eaddr}, exp_q.pop_front());
            else check("route", {estart, 16'h0000}, exp_q.pop_front());
        end
    end
    ////////////////////////////////////////////////////////////////////////////////////
    // Drivers: change on the falling edge, hold the request until ready is seen.
    task automatic do_reset(input logic s, input logic v);
        reset_in = 1'b1;
        sel_n = s;
        vpp = v;
        repeat (4) @(negedge sys_clk_in);
        reset_in = 1'b0;
        sel_n = ~s;
        vpp = 1'b0;
        @(negedge sys_clk_in);
    endtask : do_reset
    task automatic access(input logic [15:0] a, input logic ext, input logic [15:0] ea);
        req = 1'b1;
        addr = a;
        rnd = xs(rnd);
        we = rnd[0];
        exp_q.push_back({ext, ea});
        if (ext) ext_cnt++;
        if (ext) last_ea = ea;
        // A request that never becomes ready is left to the global cycle ceiling.
        while (rdy !== 1'b1) begin
            @(negedge sys_clk_in);
        end
        @(negedge sys_clk_in);
        check("bus write flag", {16'h0000, ewe}, {16'h0000, we});
    endtask : access
    task automatic finish_test(input string name);
        req = 1'b0;
        repeat (6) @(negedge sys_clk_in);
        check("notes left", 17'(exp_q.size()), 17'h00000);
        check("bus cycles", {9'h000, hits}, {9'h000, ext_cnt});
        check("memory address", {1'b0, last_addr}, {1'b0, last_ea});
        $display("test %s done", name);
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////////////
    // Main sequence: inactive, active and programming resets.
    initial begin
        do_reset(1'b1, 1'b0);
        check("active flag", {16'h0000, eact}, 17'h00000);
        check("gpio idle", {16'h0000, gpio}, 17'h00001);
        access(SP_LO, 1'b0, 16'h0000);
        access(PROG_HI, 1'b0, 16'h0000);
        access(PORT_REG_ADDR[3], 1'b0, 16'h0000);
        access(EXT_ONLY_LO, 1'b1, EXT_ONLY_LO);
        check("gpio in bus cycle", {16'h0000, gpio}, 17'h00000);
        check("busy in bus cycle", {16'h0000, ebusy}, 17'h00001);
        repeat (3) @(negedge sys_clk_in);
        check("gpio after cycle", {16'h0000, gpio}, 17'h00001);
        check("busy after cycle", {16'h0000, ebusy}, 17'h00000);
        check("ready in gap", {16'h0000, rdy}, 17'h00000);
        for (int i = 0; i < 8; i++) begin
            rnd = xs(rnd);
            access(rnd[15:0] % 16'h1fd0, 1'b0, 16'h0000);
        end
        finish_test("inactive");
        do_reset(1'b0, 1'b0);
        check("active flag", {16'h0000, eact}, 17'h00001);
        check("gpio held", {16'h0000, gpio}, 17'h00000);
        access(SP_HI, 1'b1, SP_HI);
        access(PROG_LO, 1'b1, PROG_LO);
        for (int i = 0; i < PORT_REGS; i++) begin
            access(PORT_REG_ADDR[i], 1'b1, EXT_PORT_ADDR[i]);
        end
        for (int i = 0; i < 6; i++) begin
            rnd = xs(rnd);
            if (rnd[20]) access(rnd[15:0] % 16'h1fd0, 1'b0, 16'h0000);
            else access(EXT_ONLY_LO | rnd[15:0], 1'b1, EXT_ONLY_LO | rnd[15:0]);
        end
        finish_test("active");
        do_reset(1'b1, 1'b1);
        check("prog flag", {16'h0000, pmode}, 17'h00001);
        check("prog refuses", {16'h0000, rdy}, 17'h00000);
        // A request held through programming mode must never be routed anywhere.
        req = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        req = 1'b0;
        check("prog still refuses", {16'h0000, rdy}, 17'h00000);
        do_reset(1'b1, 1'b0);
        check("prog cleared", {16'h0000, pmode}, 17'h00000);
        finish_test("programming");
        wrap_up();
    end
endmodule : test_external_access_steering
